// File: rtl/sdr_pkg.sv
// Shared constants and code-layout helpers for the protected dual-port memory
package sdr_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int SDR_DATA_W = 64;
    localparam int SDR_CHECK_W = 8;
    localparam int SDR_HAM_W = 7;
    localparam int SDR_WORD_W = SDR_DATA_W + SDR_CHECK_W;
    localparam int SDR_ADDR_W = 9;
    localparam int SDR_DEPTH = 512;
    localparam int SDR_MAX_POS = SDR_DATA_W + SDR_HAM_W;
    localparam int SDR_OVERALL_BIT = SDR_CHECK_W - 1;

    // ------------------------------------------------------------
    // Reset values of output flops and the zero syndrome
    // ------------------------------------------------------------
    localparam logic [SDR_DATA_W-1:0] SDR_DATA_RST = 64'h0000_0000_0000_0000;
    localparam logic [SDR_CHECK_W-1:0] SDR_CHECK_RST = 8'h00;
    localparam logic [SDR_HAM_W-1:0] SDR_SYN_ZERO = 7'h00;
    localparam logic SDR_FLAG_RST = 1'b0;

    typedef logic [SDR_DATA_W-1:0] sdr_data_type;
    typedef logic [SDR_CHECK_W-1:0] sdr_check_type;
    typedef logic [SDR_ADDR_W-1:0] sdr_addr_type;

    // ------------------------------------------------------------
    // Codeword position of data bit d (powers of two hold check bits)
    // ------------------------------------------------------------
    function automatic int sdr_data_pos(input int d);
        int cnt;
        int res;
        cnt = -1;
        res = 0;
        for (int p = 1; p <= SDR_MAX_POS; p++) begin
            if ((p & (p - 1)) != 0) begin
                cnt = cnt + 1;
                if (cnt == d) begin
                    res = p;
                end
            end
        end
        return res;
    endfunction

    // Data bits covered by Hamming check bit c
    function automatic sdr_data_type sdr_mask(input int c);
        sdr_data_type m;
        m = '0;
        for (int d = 0; d < SDR_DATA_W; d++) begin
            m[d] = ((sdr_data_pos(d) >> c) & 1) == 1;
        end
        return m;
    endfunction

endpackage

// File: rtl/sdr_code_if.sv
// Carrier between the memory core and its encoder and decoder
`timescale 1ns/1ps
interface sdr_code_if;
    import sdr_pkg::*;
    sdr_data_type data_in;
    sdr_check_type check_in;
    sdr_data_type data_out;
    sdr_check_type check_out;
    logic single_err;
    logic double_err;

    modport enc (input data_in, output check_out);
    modport dec (input data_in, input check_in, output data_out, output single_err,
        output double_err);
    modport core (output data_in, output check_in, input data_out, input check_out,
        input single_err, input double_err);
endinterface

// File: rtl/sdr_encoder.sv
// Check-bit generator for one 64-bit word
`timescale 1ns/1ps
module sdr_encoder (
    sdr_code_if.enc code
);
    import sdr_pkg::*;

    logic [SDR_HAM_W-1:0] ham;

    // ------------------------------------------------------------
    // Hamming bits, then overall parity over data and Hamming bits
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < SDR_HAM_W; i++) begin : g_ham
            assign ham[i] = ^(code.data_in & sdr_mask(i));
        end
    endgenerate

    assign code.check_out = {(^code.data_in) ^ (^ham), ham};
endmodule

// File: rtl/sdr_decoder.sv
// Syndrome check and single-bit correction for one stored word
`timescale 1ns/1ps
module sdr_decoder (
    sdr_code_if.dec code
);
    import sdr_pkg::*;

    logic [SDR_HAM_W-1:0] syn;
    logic overall;
    logic in_range;
    sdr_data_type flip;

    // ------------------------------------------------------------
    // Syndrome and overall parity
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < SDR_HAM_W; i++) begin : g_syn
            assign syn[i] = (^(code.data_in & sdr_mask(i))) ^ code.check_in[i];
        end
    endgenerate

    assign overall = (^code.data_in) ^ (^code.check_in);
    assign in_range = syn <= SDR_HAM_W'(SDR_MAX_POS);

    // ------------------------------------------------------------
    // Flip the one data bit the syndrome points at
    // ------------------------------------------------------------
    generate
        for (i = 0; i < SDR_DATA_W; i++) begin : g_fix
            assign flip[i] = overall && (syn == SDR_HAM_W'(sdr_data_pos(i)));
        end
    endgenerate

    assign code.data_out = code.data_in ^ flip;
    // Odd parity with a valid position is one bad bit; even parity with a nonzero syndrome, or odd parity past position 71, is uncorrectable
    assign code.single_err = overall && in_range;
    assign code.double_err = (!overall && syn != SDR_SYN_ZERO) || (overall && !in_range);
endmodule

// File: rtl/sdr_memory.sv
// Protected 512 x 64 simple dual-port memory with check-bit storage
`timescale 1ns/1ps
// Function
// - 512 words, 64 data plus 8 check
// - Encoder computes and stores check bits on write
// - Decoder corrects single, flags double errors
// - Check bits driven out every clock edge
// - Read fetches all 72 bits into decoder
// - Two flags report three read results
// - Array never rewritten by correction
// - Optional output stage on data and flags
// - Output stage adds one cycle, default off
// - Standard mode ignores external parity input
// - Decode-only stores external parity input
// - Encode-only shows stored check bits raw
// - One write-only port, one read-only port
// - Data output holds until next read
// - No read-first or write-first collision modes
// - Write only when write enable high
// - Read only when read enable high
// - Queue variant supports standard mode only
// - Encoder and decoder default to disabled
module sdr_memory #(
    parameter bit EN_ENCODE = 1'b0,
    parameter bit EN_DECODE = 1'b0,
    parameter bit OUT_REG = 1'b0
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire sdr_pkg::sdr_addr_type write_addr,
    input wire sdr_pkg::sdr_data_type write_data_in,
    input wire sdr_pkg::sdr_check_type parity_in,
    input wire logic write_enable,
    output sdr_pkg::sdr_check_type computed_check_bits,
    input wire sdr_pkg::sdr_addr_type read_addr,
    input wire logic read_enable,
    output sdr_pkg::sdr_data_type read_data_out,
    output sdr_pkg::sdr_check_type parity_out,
    output logic single_error_flag,
    output logic double_error_flag
);
    import sdr_pkg::*;

    // ------------------------------------------------------------
    // Storage and codec instances
    // ------------------------------------------------------------
    logic [SDR_WORD_W-1:0] mem [SDR_DEPTH];
    logic [SDR_WORD_W-1:0] rd_word;
    sdr_check_type store_check;
    sdr_check_type check_r;
    sdr_data_type data1_r;
    sdr_check_type par1_r;
    logic sbe1_r;
    logic dbe1_r;
    sdr_data_type data_sel;
    logic sbe_sel;
    logic dbe_sel;

    sdr_code_if enc_bus ();
    sdr_code_if dec_bus ();

    sdr_encoder u_enc (
        .code(enc_bus.enc)
    );

    sdr_decoder u_dec (
        .code(dec_bus.dec)
    );

    assign enc_bus.data_in = write_data_in;
    assign enc_bus.check_in = SDR_CHECK_RST;
    assign rd_word = mem[read_addr];
    assign dec_bus.data_in = rd_word[SDR_DATA_W-1:0];
    assign dec_bus.check_in = rd_word[SDR_WORD_W-1:SDR_DATA_W];

    // ------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------
    // Generated bits in standard or encode-only; external bits in decode-only
    // Memory variant: all three modes; a queue build pins both enables high
    assign store_check = EN_ENCODE ? enc_bus.check_out : parity_in;

    // Plain write port: array content only ever changes here
    always_ff @(posedge mclk) begin
        if (write_enable) begin
            mem[write_addr] <= {store_check, write_data_in};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            check_r <= SDR_CHECK_RST;
        end else begin
            check_r <= enc_bus.check_out;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Same-address read in a write cycle returns the old word only
    assign data_sel = EN_DECODE ? dec_bus.data_out : dec_bus.data_in;
    assign sbe_sel = EN_DECODE && dec_bus.single_err;
    assign dbe_sel = EN_DECODE && dec_bus.double_err;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            data1_r <= SDR_DATA_RST;
            par1_r <= SDR_CHECK_RST;
            sbe1_r <= SDR_FLAG_RST;
            dbe1_r <= SDR_FLAG_RST;
        end else if (read_enable) begin
            data1_r <= data_sel;
            par1_r <= dec_bus.check_in;
            sbe1_r <= sbe_sel;
            dbe1_r <= dbe_sel;
        end
    end

    assign computed_check_bits = check_r;
    assign parity_out = par1_r;

    // ------------------------------------------------------------
    // Optional output stage
    // ------------------------------------------------------------
    generate
        if (OUT_REG) begin : g_oreg
            sdr_data_type data2_r;
            logic sbe2_r;
            logic dbe2_r;
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    data2_r <= SDR_DATA_RST;
                    sbe2_r <= SDR_FLAG_RST;
                    dbe2_r <= SDR_FLAG_RST;
                end else begin
                    data2_r <= data1_r;
                    sbe2_r <= sbe1_r;
                    dbe2_r <= dbe1_r;
                end
            end
            assign read_data_out = data2_r;
            assign single_error_flag = sbe2_r;
            assign double_error_flag = dbe2_r;
        end else begin : g_noreg
            assign read_data_out = data1_r;
            assign single_error_flag = sbe1_r;
            assign double_error_flag = dbe1_r;
        end
    endgenerate
endmodule

// File: bench/sdr_memory_props.sv
// Port assertions for the protected memory
`timescale 1ns/1ps
module sdr_memory_props #(
    parameter bit EN_ENCODE = 1'b0,
    parameter bit EN_DECODE = 1'b0,
    parameter bit OUT_REG = 1'b0
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire sdr_pkg::sdr_addr_type write_addr,
    input wire sdr_pkg::sdr_data_type write_data_in,
    input wire sdr_pkg::sdr_check_type parity_in,
    input wire logic write_enable,
    input wire sdr_pkg::sdr_check_type computed_check_bits,
    input wire sdr_pkg::sdr_addr_type read_addr,
    input wire logic read_enable,
    input wire sdr_pkg::sdr_data_type read_data_out,
    input wire sdr_pkg::sdr_check_type parity_out,
    input wire logic single_error_flag,
    input wire logic double_error_flag
);
    import sdr_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    a_flags_onehot: assert property (!(single_error_flag && double_error_flag))
        else $error("both flags high");
    a_std_clean: assert property (
        EN_ENCODE && EN_DECODE |-> !(single_error_flag || double_error_flag))
        else $error("flag in standard mode");
    a_flag_cause: assert property (
        $rose(single_error_flag) |-> $past(read_enable, 1 + OUT_REG))
        else $error("flag without read");
    a_out_hold: assert property (
        !$past(read_enable, 1 + OUT_REG) |->
        $stable({read_data_out, single_error_flag, double_error_flag}))
        else $error("output moved without read");
    a_par_hold: assert property (!$past(read_enable) |-> $stable(parity_out))
        else $error("parity moved without read");
    a_check_follow: assert property (
        EN_ENCODE && $stable(write_data_in) |=> $stable(computed_check_bits))
        else $error("check bits unstable");
    a_stored_par: assert property (
        $past(write_enable, 2) && $past(read_enable) &&
        $past(read_addr) == $past(write_addr, 2) |->
        parity_out == (EN_ENCODE ? $past(computed_check_bits) : $past(parity_in, 2)))
        else $error("stored check bits wrong");
    a_read_data: assert property (
        EN_ENCODE && EN_DECODE && !OUT_REG && $past(write_enable, 2) &&
        $past(read_enable) && $past(read_addr) == $past(write_addr, 2) |->
        read_data_out == $past(write_data_in, 2))
        else $error("read data wrong");
    c_single: cover property (single_error_flag);
    c_double: cover property (double_error_flag);
    c_wr_rd: cover property (write_enable ##1 read_enable);
endmodule

// File: bench/sdr_fabric.sv
// User-side driver of the write and read ports
`timescale 1ns/1ps
module sdr_fabric (
    input wire logic mclk,
    output sdr_pkg::sdr_addr_type write_addr,
    output sdr_pkg::sdr_data_type write_data_in,
    output sdr_pkg::sdr_check_type parity_in,
    output logic write_enable,
    output sdr_pkg::sdr_addr_type read_addr,
    output logic read_enable
);
    import sdr_pkg::*;
    // Output set/reset has no pin, so it stays low
    initial begin
        {write_addr, write_data_in, parity_in, write_enable, read_addr, read_enable} = '0;
    end
    task automatic wr(input sdr_addr_type a, input sdr_data_type d, input sdr_check_type p,
        input logic we);
        @(posedge mclk);
        write_addr <= a;
        write_data_in <= d;
        parity_in <= p;
        write_enable <= we;
    endtask
    // Read taken one cycle after the write, so equal addresses see the new word
    task automatic rd(input sdr_addr_type a, input logic en);
        @(posedge mclk);
        write_enable <= 1'b0;
        read_addr <= a;
        read_enable <= en;
        @(posedge mclk);
        read_enable <= 1'b0;
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the protected memory
`timescale 1ns/1ps
module tb_top;
    import sdr_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic write_enable, read_enable, single_error_flag, double_error_flag, sef_b, def_b;
    logic sef_c, def_c;
    sdr_addr_type write_addr, read_addr;
    sdr_data_type write_data_in, read_data_out, dout_b, dout_c;
    sdr_check_type parity_in, computed_check_bits, parity_out, pout_b, pout_c;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    sdr_fabric u_sdr_fabric (.*);
    sdr_memory #(.EN_ENCODE(1'b1), .EN_DECODE(1'b1)) u_sdr_memory (.*);
    sdr_memory #(.EN_DECODE(1'b1), .OUT_REG(1'b1)) u_sdr_memory_b (.*,
        .computed_check_bits(), .read_data_out(dout_b), .parity_out(pout_b),
        .single_error_flag(sef_b), .double_error_flag(def_b));
    // Encode-only build
    sdr_memory #(.EN_ENCODE(1'b1)) u_sdr_memory_c (.*,
        .computed_check_bits(), .read_data_out(dout_c), .parity_out(pout_c),
        .single_error_flag(sef_c), .double_error_flag(def_c));
    always #10 mclk = ~mclk;
    function automatic sdr_check_type chk(input sdr_data_type d);
        sdr_check_type c;
        int p;
        c = '0;
        p = 1;
        for (int i = 0; i < 64; i++) begin
            while ((p & (p - 1)) == 0) p++;
            for (int b = 0; b < 7; b++) c[b] ^= d[i] & p[b];
            p++;
        end
        c[7] = ^{c[6:0], d};
        return c;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        n_checks++;
        if (seen !== want) begin
            err_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 1000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic t_std;
        sdr_data_type d;
        d = 64'hdead_beef_0123_4567;
        u_sdr_fabric.wr(9'h1ff, d, 8'h5a, 1'b1);
        u_sdr_fabric.rd(9'h1ff, 1'b1);
        @(posedge mclk);
        #1;
        check(64'(computed_check_bits), 64'(chk(d)));
        check(read_data_out, d);
        check(64'(parity_out), 64'(chk(d)));
        check(64'({single_error_flag, double_error_flag}), 64'h0);
        check(64'(pout_c), 64'(chk(d)));
        check(dout_c, d);
        check(64'({sef_c, def_c}), 64'h0);
        u_sdr_fabric.wr(9'h1ff, ~d, 8'h00, 1'b0);
        u_sdr_fabric.rd(9'h000, 1'b0);
        #1;
        check(64'(computed_check_bits), 64'(chk(~d)));
        check(read_data_out, d);
        u_sdr_fabric.rd(9'h1ff, 1'b1);
        #1;
        check(read_data_out, d);
    endtask
    task automatic t_dec(input sdr_data_type df, input sdr_check_type pf, input logic [1:0] f);
        sdr_data_type d;
        d = 64'h0f1e_2d3c_4b5a_6978;
        u_sdr_fabric.wr(9'h0a5, d ^ df, chk(d) ^ pf, 1'b1);
        repeat (2) begin
            u_sdr_fabric.rd(9'h0a5, 1'b1);
            @(posedge mclk);
            #1;
            check(64'({sef_b, def_b}), 64'(f));
            if (!f[0]) check(dout_b, d);
            check(64'(pout_b), 64'(chk(d) ^ pf));
        end
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        t_std();
        t_dec(64'h0, 8'h00, 2'b00);
        t_dec(64'h1, 8'h00, 2'b10);
        t_dec(64'h8000_0000_0000_0000, 8'h00, 2'b10);
        t_dec(64'h0, 8'h01, 2'b10);
        t_dec(64'h0, 8'h80, 2'b10);
        t_dec(64'h3, 8'h00, 2'b01);
        t_dec(64'h1, 8'h02, 2'b01);
        tally_and_finish();
    end
endmodule
bind sdr_memory sdr_memory_props #(.EN_ENCODE(EN_ENCODE), .EN_DECODE(EN_DECODE),
    .OUT_REG(OUT_REG)) u_sdr_memory_props (.*);
